/* File: logic/mci_cmd_irq.sv */
/*
 * APB register slave holding the two command slots, their
 * completion events and the interrupt enables.
 * Assumes the shift engine runs on CLK_SYS_I, reads the slot fields
 * while its launch flag is high and pulses ENG_DONE_I for one cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module mci_cmd_irq
	import mci_pkg::*;
(
	input  wire logic                  CLK_SYS_I,
	input  wire logic                  NRST_I,
	input  wire logic                  CE_I,
	input  wire logic                  PSEL_I,
	input  wire logic                  PENABLE_I,
	input  wire logic                  PWRITE_I,
	input  wire logic [MCI_ADDR_W-1:0] PADDR_I,
	input  wire logic [31:0]           PWDATA_I,
	output logic      [31:0]           PRDATA_O,
	output logic                       PREADY_O,
	output logic                       PSLVERR_O,
	output logic      [1:0]            ENG_GO_O,
	output logic      [1:0]            ENG_DIR_O,
	output logic      [9:0]            ENG_REGIDX_O,
	output logic      [9:0]            ENG_PHYSEL_O,
	output logic      [31:0]           ENG_WDATA_O,
	input  wire logic [1:0]            ENG_DONE_I,
	input  wire logic                  ENG_ACK_I,
	input  wire logic [15:0]           ENG_RDATA_I,
	output logic                       CMD_DONE_IRQ_O
);

	mci_state_t st_reg;   // Registered state
	mci_state_t st_next;  // Next state
	logic       xfer;     // Completing APB access
	logic       wr;       // Completing write

	// Packs one slot into the command word layout
	function automatic logic [31:0] mci_pack(input logic go, input logic dir, input logic ack,
		input logic [4:0] ri, input logic [4:0] ps, input logic [15:0] d);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[MCI_GO_BIT] = go;
		w[MCI_DIR_BIT] = dir;
		w[MCI_ACK_BIT] = ack;
		w[MCI_REG_LSB +: 5] = ri;
		w[MCI_PHY_LSB +: 5] = ps;
		w[MCI_DATA_LSB +: 16] = d;
		return w;
	endfunction : mci_pack

	// Bus handshake; a frozen block stalls the bus
	assign PREADY_O  = PENABLE_I & st_reg.hit & CE_I;
	assign xfer      = PSEL_I & PENABLE_I & PREADY_O;
	assign wr        = xfer & PWRITE_I;
	assign PRDATA_O  = st_reg.prdata;
	assign PSLVERR_O = xfer & st_reg.err;

	// Engine side straight from flops
	assign ENG_GO_O     = st_reg.go;
	assign ENG_DIR_O    = st_reg.dir;
	assign ENG_REGIDX_O = {st_reg.regidx[1], st_reg.regidx[0]};
	assign ENG_PHYSEL_O = {st_reg.physel[1], st_reg.physel[0]};
	assign ENG_WDATA_O  = {st_reg.data[1], st_reg.data[0]};

	assign CMD_DONE_IRQ_O = |(st_reg.raw & st_reg.en);

	// Next-state logic
	always_comb begin
		st_next = st_reg;
		// Capture read data once per transfer, before the access completes
		if (PSEL_I && !st_reg.hit) begin
			st_next.hit = 1'b1;
			st_next.err = 1'b0;
			unique case (PADDR_I)
				MCI_OFF_RAW:    st_next.prdata = {30'h0, st_reg.raw};
				MCI_OFF_MASKED: st_next.prdata = {30'h0, st_reg.raw & st_reg.en};
				MCI_OFF_ENSET:  st_next.prdata = {30'h0, st_reg.en};
				MCI_OFF_ENCLR:  st_next.prdata = {30'h0, ~st_reg.en};
				MCI_OFF_CMD0:   st_next.prdata = mci_pack(st_reg.go[0], st_reg.dir[0], st_reg.ack[0],
					st_reg.regidx[0], st_reg.physel[0], st_reg.data[0]);
				MCI_OFF_CMD1:   st_next.prdata = mci_pack(st_reg.go[1], st_reg.dir[1], st_reg.ack[1],
					st_reg.regidx[1], st_reg.physel[1], st_reg.data[1]);
				default: begin
					// Unmapped reads zero with an error
					st_next.prdata = 32'h0000_0000;
					st_next.err    = 1'b1;
				end
			endcase
		end
		if (xfer) begin
			st_next.hit = 1'b0;
		end
		// Register writes; only bits 1:0 count on enable and event registers
		if (wr) begin
			unique case (PADDR_I)
				MCI_OFF_RAW, MCI_OFF_MASKED: st_next.raw = st_reg.raw & ~PWDATA_I[1:0];
				// write 1 sets; zero no effect
				MCI_OFF_ENSET: st_next.en = st_reg.en | PWDATA_I[1:0];
				// write 1 clears; zero no effect
				MCI_OFF_ENCLR: st_next.en = st_reg.en & ~PWDATA_I[1:0];
				default: ;
			endcase
		end
		for (int n = 0; n < MCI_SLOTS; n++) begin
			if (wr && !st_reg.go[n] && PADDR_I == (n == 0 ? MCI_OFF_CMD0 : MCI_OFF_CMD1)) begin
				st_next.go[n]     = PWDATA_I[MCI_GO_BIT];
				st_next.dir[n]    = PWDATA_I[MCI_DIR_BIT];
				st_next.ack[n]    = PWDATA_I[MCI_ACK_BIT];
				st_next.regidx[n] = PWDATA_I[MCI_REG_LSB +: 5];
				st_next.physel[n] = PWDATA_I[MCI_PHY_LSB +: 5];
				st_next.data[n]   = PWDATA_I[MCI_DATA_LSB +: 16];
			end
			if (ENG_DONE_I[n] && st_reg.go[n]) begin
				st_next.go[n]  = 1'b0;
				st_next.ack[n] = ENG_ACK_I;
				if (!st_reg.dir[n]) begin
					st_next.data[n] = ENG_RDATA_I;
				end
				st_next.raw[n] = 1'b1;
			end
		end
	end

	// State register; clock enable freezes everything except the synchronous reset
	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I) begin
			st_reg        <= '0;
			st_reg.en     <= MCI_EN_RST;
			st_reg.raw    <= MCI_RAW_RST;
			st_reg.regidx <= {MCI_FLD5_RST, MCI_FLD5_RST};
			st_reg.physel <= {MCI_FLD5_RST, MCI_FLD5_RST};
			st_reg.data   <= {MCI_DATA_RST, MCI_DATA_RST};
		end else if (CE_I) begin
			st_reg <= st_next;
		end
	end

	AST_ENSET: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
		wr && PADDR_I == MCI_OFF_ENSET && PWDATA_I[0] |=> st_reg.en[0])
		else $error("Enable set write did not enable slot 0");

	AST_NOIRQ: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
		st_reg.en == 2'h0 && !wr |=> !CMD_DONE_IRQ_O)
		else $error("Interrupt raised with both slots disabled");

	AST_ZEROWR: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
		wr && (PADDR_I == MCI_OFF_ENSET || PADDR_I == MCI_OFF_ENCLR) && PWDATA_I[1:0] == 2'h0
		|=> $stable(st_reg.en))
		else $error("Zero write changed enable state");

	AST_ENCLR: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
		wr && PADDR_I == MCI_OFF_ENCLR && PWDATA_I[1] |=> !st_reg.en[1])
		else $error("Enable clear write did not disable slot 1");

	AST_ENREAD: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
		xfer && !PWRITE_I && PADDR_I == MCI_OFF_ENCLR |-> PRDATA_O == {30'h0, ~st_reg.en})
		else $error("Enable clear read wrong");
	AST_ENSETRD: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
		xfer && !PWRITE_I && PADDR_I == MCI_OFF_ENSET |-> PRDATA_O == {30'h0, st_reg.en})
		else $error("Enable set read wrong");

	AST_LAYOUT: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
		xfer && !PWRITE_I && PADDR_I == MCI_OFF_CMD0 && !$past(ENG_DONE_I[0])
		|-> PRDATA_O[28:26] == 3'h0 && PRDATA_O[25:21] == st_reg.regidx[0] && PRDATA_O[20:16] == st_reg.physel[0])
		else $error("Command word fields misplaced");

	AST_SELFCLR: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
		CE_I && st_reg.go[0] && ENG_DONE_I[0] |=> !st_reg.go[0] && st_reg.raw[0])
		else $error("Launch flag did not self-clear");

	AST_BLOCK: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
		wr && st_reg.go[1] && !ENG_DONE_I[1] && PADDR_I == MCI_OFF_CMD1
		|=> $stable(st_reg.regidx[1]) && $stable(st_reg.data[1]) && st_reg.go[1])
		else $error("Command write accepted while launched");

	AST_RAW: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
		CE_I && st_reg.go[1] && ENG_DONE_I[1] && !st_reg.en[1] |=> st_reg.raw[1])
		else $error("Raw event not set on completion");

	AST_IRQ: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
		CE_I && st_reg.go[0] && ENG_DONE_I[0] && st_reg.en[0] && !wr |=> CMD_DONE_IRQ_O)
		else $error("Enabled completion raised no interrupt");

	AST_RSVD: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
		xfer && !PWRITE_I && (PADDR_I == MCI_OFF_ENSET || PADDR_I == MCI_OFF_ENCLR || PADDR_I == MCI_OFF_MASKED)
		|-> PRDATA_O[31:2] == 30'h0)
		else $error("Reserved enable bits not zero");

	AST_LAUNCH: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
		wr && PADDR_I == MCI_OFF_CMD0 && !st_reg.go[0] && PWDATA_I[MCI_GO_BIT] |=> ENG_GO_O[0])
		else $error("Launch flag not set by write");

	// masked read back; a completion at the capture edge is not yet seen
	AST_MASKRD: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
		xfer && !PWRITE_I && PADDR_I == MCI_OFF_MASKED && $past(ENG_DONE_I) == 2'h0
		|-> PRDATA_O[1:0] == (st_reg.raw & st_reg.en))
		else $error("Masked status read wrong");

endmodule : mci_cmd_irq

`default_nettype wire

/* File: logic/mci_pkg.sv */
/*
 * Constants, field layout and state type for the command-complete
 * interrupt enable block of the management-serial controller.
 * Assumes a 32-bit APB master on the system clock and an external
 * shift engine on the same clock.
 *
 */
`default_nettype none

package mci_pkg;

	// Bus geometry
	localparam int MCI_ADDR_W = 8;
	localparam int MCI_SLOTS  = 2;

	// Register byte offsets
	localparam logic [7:0] MCI_OFF_RAW    = 8'h00;
	localparam logic [7:0] MCI_OFF_MASKED = 8'h04;
	localparam logic [7:0] MCI_OFF_ENSET  = 8'h08;
	localparam logic [7:0] MCI_OFF_ENCLR  = 8'h0C;
	localparam logic [7:0] MCI_OFF_CMD0   = 8'h10;
	localparam logic [7:0] MCI_OFF_CMD1   = 8'h14;

	// Command word field positions
	localparam int MCI_GO_BIT    = 31;
	localparam int MCI_DIR_BIT   = 30;
	localparam int MCI_ACK_BIT   = 29;
	localparam int MCI_REG_LSB   = 21;
	localparam int MCI_PHY_LSB   = 16;
	localparam int MCI_DATA_LSB  = 0;

	// Reset values
	localparam logic [1:0]  MCI_EN_RST   = 2'h0;
	localparam logic [1:0]  MCI_RAW_RST  = 2'h0;
	localparam logic [4:0]  MCI_FLD5_RST = 5'h00;
	localparam logic [15:0] MCI_DATA_RST = 16'h0000;

	// Whole block state
	typedef struct packed {
		logic [1:0]       en;      // Shared enable per slot
		logic [1:0]       raw;     // Sticky completion events
		logic [1:0]       go;      // Launch flags
		logic [1:0]       dir;     // 1 = PHY write
		logic [1:0]       ack;     // PHY acknowledged
		logic [1:0][4:0]  regidx;  // PHY register index
		logic [1:0][4:0]  physel;  // PHY select
		logic [1:0][15:0] data;    // Write or read data
		logic [31:0]      prdata;  // Captured read data
		logic             err;     // Captured unmapped flag
		logic             hit;     // Read data captured
	} mci_state_t;

endpackage : mci_pkg

`default_nettype wire

/* File: dv/mci_cmd_irq_bench.sv */
/*
 * Self-checking bench for the command-complete interrupt enable block.
 * Assumes the zero-wait APB slave and the one-cycle done pulses
 * described by the designer; the bench stands in for the engine.
 */
`timescale 1ns/1ps
`default_nettype none

module mci_cmd_irq_bench;
	import mci_pkg::*;

	logic        clk, nrst, ce, psel, pen, pwr;  // Clock, reset, APB controls
	logic [7:0]  paddr;                          // APB byte address
	logic [31:0] pwdata, prdata;                 // APB data
	logic        pready, pslverr, irq, ack;      // Answers, interrupt, engine ack
	logic [1:0]  go, dir, done;                  // Engine handshake
	logic [9:0]  regidx, physel;                 // Engine fields
	logic [31:0] wdata;                          // Engine write data
	logic [15:0] rdata_eng;                      // Engine read data
	int          fails, compares;                // Counters
	logic [31:0] rd;                             // Last read word
	logic        er;                             // Last error flag

	mci_cmd_irq dut (.CLK_SYS_I(clk), .NRST_I(nrst), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .ENG_GO_O(go), .ENG_DIR_O(dir), .ENG_REGIDX_O(regidx),
		.ENG_PHYSEL_O(physel), .ENG_WDATA_O(wdata), .ENG_DONE_I(done), .ENG_ACK_I(ack),
		.ENG_RDATA_I(rdata_eng), .CMD_DONE_IRQ_O(irq));

	// Free-running 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Report counts and end the run
	task close_out;
		$display("Checks %0d, mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out

	// One compare, counted
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	// One APB transfer; an idle edge after it keeps drives apart
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel   <= 1'b1;
		pen    <= 1'b0;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		// Slave may stall; only the watchdog ends a hang
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
		@(posedge clk);
	endtask : apb

	// Read a register and compare the word
	task rchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp, msg);
	endtask : rchk

	// Engine completion pulse for one slot
	task finish_slot(input int n, input logic a, input logic [15:0] d);
		done[n]   <= 1'b1;
		ack       <= a;
		rdata_eng <= d;
		@(posedge clk);
		done <= 2'h0;
		@(posedge clk);
	endtask : finish_slot

	// Reset values, enable set and clear, reserved bits
	task t_enables;
		rchk(MCI_OFF_ENSET, 32'h0000_0000, "enset reset");
		rchk(MCI_OFF_ENCLR, 32'h0000_0003, "enclr reset");
		rchk(MCI_OFF_CMD0, 32'h0000_0000, "cmd0 reset");
		apb(1'b1, MCI_OFF_ENSET, 32'hFFFF_FFFD);
		rchk(MCI_OFF_ENSET, 32'h0000_0001, "enset slot0");
		rchk(MCI_OFF_ENCLR, 32'h0000_0002, "enclr slot0");
		apb(1'b1, MCI_OFF_ENSET, 32'h0000_0000);
		apb(1'b1, MCI_OFF_ENCLR, 32'h0000_0000);
		rchk(MCI_OFF_ENSET, 32'h0000_0001, "zero writes");
	endtask : t_enables

	// Launch, blocked rewrite, completion with interrupt
	task t_slot0;
		apb(1'b1, MCI_OFF_CMD0, 32'h80A3_1234);
		chk({30'h0, go}, 32'h0000_0001, "go slot0");
		chk({17'h0, regidx[4:0], physel[4:0], 5'h00}, {17'h0, 5'h05, 5'h03, 5'h00}, "fields");
		chk({16'h0, wdata[15:0]}, 32'h0000_1234, "wdata");
		apb(1'b1, MCI_OFF_CMD0, 32'h0000_0000);
		rchk(MCI_OFF_CMD0, 32'h80A3_1234, "blocked write");
		chk({31'h0, irq}, 32'h0, "irq early");
		finish_slot(0, 1'b1, 16'hBEEF);
		chk({30'h0, go}, 32'h0, "go cleared");
		chk({31'h0, irq}, 32'h1, "irq on done");
		rchk(MCI_OFF_CMD0, 32'h20A3_BEEF, "cmd0 after");
		rchk(MCI_OFF_MASKED, 32'h0000_0001, "masked");
	endtask : t_slot0

	// Disabled slot completes silently, then is enabled
	task t_slot1;
		apb(1'b1, MCI_OFF_ENCLR, 32'hFFFF_FFFD);
		chk({31'h0, irq}, 32'h0, "irq masked off");
		rchk(MCI_OFF_ENCLR, 32'h0000_0003, "enclr all");
		apb(1'b1, MCI_OFF_CMD1, 32'hC000_5555);
		chk({30'h0, dir}, 32'h0000_0002, "dir slot1");
		chk({16'h0, wdata[31:16]}, 32'h0000_5555, "wdata slot1");
		finish_slot(1, 1'b0, 16'h0F0F);
		chk({31'h0, irq}, 32'h0, "irq disabled");
		rchk(MCI_OFF_RAW, 32'h0000_0003, "raw both");
		rchk(MCI_OFF_MASKED, 32'h0000_0000, "masked none");
		rchk(MCI_OFF_CMD1, 32'h4000_5555, "cmd1 after");
		apb(1'b1, MCI_OFF_ENSET, 32'h0000_0002);
		chk({31'h0, irq}, 32'h1, "irq slot1");
		apb(1'b1, MCI_OFF_RAW, 32'h0000_0001);
		chk({31'h0, irq}, 32'h1, "irq after raw0 clear");
		apb(1'b1, MCI_OFF_MASKED, 32'h0000_0002);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk({er, rd}, {1'b1, 32'h0}, "unmapped");
	endtask : t_slot1

	// Clock enable low stalls a write until it returns
	task t_freeze;
		ce <= 1'b0;
		fork
			apb(1'b1, MCI_OFF_ENSET, 32'h0000_0001);
			begin
				repeat (3) @(posedge clk);
				chk({31'h0, pready}, 32'h0, "ready while frozen");
				ce <= 1'b1;
			end
		join
		rchk(MCI_OFF_ENSET, 32'h0000_0003, "enset after freeze");
	endtask : t_freeze

	// Main sequence
	initial begin
		fails     = 0;
		compares  = 0;
		nrst      = 1'b0;
		ce        = 1'b1;
		psel      = 1'b0;
		pen       = 1'b0;
		pwr       = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0;
		done      = 2'h0;
		ack       = 1'b0;
		rdata_eng = 16'h0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_enables;
		t_slot0;
		t_slot1;
		t_freeze;
		close_out;
	end

	// Watchdog, far beyond the hundred or so cycles needed
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		close_out;
	end

endmodule : mci_cmd_irq_bench

`default_nettype wire
